// ---- hdl/gpio_cfg_pkg.sv ----
// Shared constants and types for the general-purpose pin configuration bank
`default_nettype none

package gpio_cfg_pkg;

    // ************************************************************
    // Register indices and byte addresses (address = 4 * index)
    // ************************************************************
    localparam logic [7:0] IDX_PIN_THREE   = 8'h1f;
    localparam logic [7:0] IDX_PINS_56     = 8'h20;
    localparam logic [7:0] IDX_PINS_78     = 8'h21;
    localparam logic [7:0] IDX_PAD_LEVELS  = 8'h30;
    localparam logic [9:0] ADDR_PIN_THREE  = {IDX_PIN_THREE, 2'b00};
    localparam logic [9:0] ADDR_PINS_56    = {IDX_PINS_56, 2'b00};
    localparam logic [9:0] ADDR_PINS_78    = {IDX_PINS_78, 2'b00};
    localparam logic [9:0] ADDR_PAD_LEVELS = {IDX_PAD_LEVELS, 2'b00};

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int LO_OUT_BIT    = 3;
    localparam int REMOTE_BIT    = 2;
    localparam int LO_DIR_BIT    = 1;
    localparam int LO_EN_BIT     = 0;
    localparam int HI_OUT_BIT    = 7;
    localparam int HI_DIR_BIT    = 5;
    localparam int HI_EN_BIT     = 4;
    localparam int PIN_THREE_MSB = 3;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [7:0]  PAIR_RESET      = 8'h00;
    localparam logic [3:0]  PIN_THREE_RESET = 4'h0;
    localparam logic [1:0]  STRAP_SETTLE    = 2'h3;
    localparam int          PAD_COUNT       = 6;

    // Pad slots: primary pin three, duplicate pin three, pins five to eight
    localparam int SLOT_P3  = 0;
    localparam int SLOT_DP3 = 1;
    localparam int SLOT_P5  = 2;
    localparam int SLOT_P6  = 3;
    localparam int SLOT_P7  = 4;
    localparam int SLOT_P8  = 5;

    // {direction, enable} pad modes
    typedef enum logic [1:0] {
        MODE_FUNC     = 2'b00,
        MODE_GPIO_OUT = 2'b01,
        MODE_TRISTATE = 2'b10,
        MODE_GPIO_IN  = 2'b11
    } pad_mode_t;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_INIT = 2'b00,
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

endpackage : gpio_cfg_pkg

`default_nettype wire

// ---- hdl/gpio_pin_config_bank.sv ----
// Pin configuration bank: Avalon-MM registers steering six general-purpose pads
// Behaviour
// R1: Drive local value in enabled output mode
// R2: Remote bit forces output of far value
// R3: Decode direction/enable pair into pad mode
// R4: Pin three pair resets to strap level
// R5: Strap moves pin three control to duplicate
// R6: Pin three fields; upper nibble reads zero
// R7: Paired registers: high pin 7/5/4, low 3/1/0
// R8: Paired registers reset zero; reserved bits writable
// R9: Synchronise pad inputs before use
`timescale 1ns/10ps
`default_nettype none

module gpio_pin_config_bank
    import gpio_cfg_pkg::*;
(
    input  wire logic        ref_clk_i,            // 20 MHz register clock
    input  wire logic        rst_i,                // Async reset, active high
    input  wire logic [9:0]  avs_address_i,        // Byte address
    input  wire logic        avs_read_i,           // Read request
    input  wire logic        avs_write_i,          // Write request
    input  wire logic [3:0]  avs_byteenable_i,     // Byte enables
    input  wire logic [31:0] avs_writedata_i,      // Write data
    output logic [31:0]      avs_readdata_o,       // Read data
    output logic             avs_waitrequest_o,    // Stall
    input  wire logic        second_port_strap_i,  // Port-select strap pin
    input  wire logic        remote_pin_three_i,   // Far-end value for pin three
    input  wire logic [5:0]  func_value_i,         // Functional outputs per slot
    input  wire logic [5:0]  pad_i,                // Pad levels in
    output logic [5:0]       pad_o,                // Pad levels out
    output logic [5:0]       pad_oe_o,             // Pad output enables
    output logic [5:0]       pad_level_o,          // Synchronised pad levels
    output logic             strap_latched_o       // Captured strap value
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [3:0]  pin_three_config;
    logic [7:0]  pins_five_six_config;
    logic [7:0]  pins_seven_eight_config;
    bus_state_t  bus_state;
    logic [1:0]  settle_cnt;
    logic        strap_meta;
    logic        strap_sync;
    logic        settle_done;
    logic        wr_accept;
    logic        wr_lane0;
    logic [31:0] next_readdata;
    logic [5:0]  cfg_dir;
    logic [5:0]  cfg_en;
    logic [5:0]  cfg_out;
    logic [5:0]  cfg_remote;
    logic [5:0]  sync_level;

    // ************************************************************
    // Strap capture
    // ************************************************************
    // Strap is a pin, so it crosses two flops first
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end else begin
            strap_meta <= second_port_strap_i;
            strap_sync <= strap_meta;
        end
    end

    // Wait for the synchroniser to fill before trusting the strap
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle_cnt <= 2'h0;
        end else if (settle_cnt != STRAP_SETTLE) begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    assign settle_done = (settle_cnt == STRAP_SETTLE);

    // Latch once; later strap movement is ignored until the next reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_latched_o <= 1'b0;
        end else if (bus_state == BUS_INIT && settle_done) begin
            strap_latched_o <= strap_sync;
        end
    end

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    // Write lands at the edge where the master sees waitrequest low
    assign wr_accept = avs_write_i && !avs_waitrequest_o;
    assign wr_lane0  = wr_accept && avs_byteenable_i[0];

    // Init holds off the bus until the strap default is loaded
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_state         <= BUS_INIT;
            avs_waitrequest_o <= 1'b1;
        end else begin
            case (bus_state)
                BUS_INIT: begin
                    if (settle_done) begin
                        bus_state <= BUS_IDLE;
                    end
                end
                BUS_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_state         <= BUS_ACK;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    bus_state         <= BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
                default: begin
                    bus_state         <= BUS_INIT;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address_i)
            // R6: upper nibble reads zero
            ADDR_PIN_THREE:  next_readdata = {28'h000_0000, pin_three_config};
            ADDR_PINS_56:    next_readdata = {24'h00_0000, pins_five_six_config};
            ADDR_PINS_78:    next_readdata = {24'h00_0000, pins_seven_eight_config};
            ADDR_PAD_LEVELS: next_readdata = {26'h000_0000, sync_level};
            default:         next_readdata = 32'h0000_0000;
        endcase
    end

    // Data is ready in the same cycle waitrequest drops
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (bus_state == BUS_IDLE && avs_read_i) begin
            avs_readdata_o <= next_readdata;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_three_config <= PIN_THREE_RESET;
        end else if (bus_state == BUS_INIT && settle_done) begin
            // R4: strap sets direction and enable
            pin_three_config[LO_DIR_BIT] <= strap_sync;
            pin_three_config[LO_EN_BIT]  <= strap_sync;
        end else if (wr_lane0 && avs_address_i == ADDR_PIN_THREE) begin
            // R6: only low nibble stored
            pin_three_config <= avs_writedata_i[PIN_THREE_MSB:0];
        end
    end

    // R8: paired registers reset zero, all bits writable
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pins_five_six_config    <= PAIR_RESET;
            pins_seven_eight_config <= PAIR_RESET;
        end else if (wr_lane0) begin
            if (avs_address_i == ADDR_PINS_56) begin
                pins_five_six_config <= avs_writedata_i[7:0];
            end
            if (avs_address_i == ADDR_PINS_78) begin
                pins_seven_eight_config <= avs_writedata_i[7:0];
            end
        end
    end

    // ************************************************************
    // Per-slot field routing
    // ************************************************************
    // R5: strap selects which pin three pad obeys the register
    always_comb begin
        cfg_dir    = 6'h00;
        cfg_en     = 6'h00;
        cfg_out    = 6'h00;
        cfg_remote = 6'h00;
        if (strap_latched_o) begin
            cfg_dir[SLOT_DP3]    = pin_three_config[LO_DIR_BIT];
            cfg_en[SLOT_DP3]     = pin_three_config[LO_EN_BIT];
            cfg_out[SLOT_DP3]    = pin_three_config[LO_OUT_BIT];
            cfg_remote[SLOT_DP3] = pin_three_config[REMOTE_BIT];
        end else begin
            cfg_dir[SLOT_P3]    = pin_three_config[LO_DIR_BIT];
            cfg_en[SLOT_P3]     = pin_three_config[LO_EN_BIT];
            cfg_out[SLOT_P3]    = pin_three_config[LO_OUT_BIT];
            cfg_remote[SLOT_P3] = pin_three_config[REMOTE_BIT];
        end
        // R7: high pin in upper fields, low pin in lower
        cfg_dir[SLOT_P5] = pins_five_six_config[LO_DIR_BIT];
        cfg_en[SLOT_P5]  = pins_five_six_config[LO_EN_BIT];
        cfg_out[SLOT_P5] = pins_five_six_config[LO_OUT_BIT];
        cfg_dir[SLOT_P6] = pins_five_six_config[HI_DIR_BIT];
        cfg_en[SLOT_P6]  = pins_five_six_config[HI_EN_BIT];
        cfg_out[SLOT_P6] = pins_five_six_config[HI_OUT_BIT];
        cfg_dir[SLOT_P7] = pins_seven_eight_config[LO_DIR_BIT];
        cfg_en[SLOT_P7]  = pins_seven_eight_config[LO_EN_BIT];
        cfg_out[SLOT_P7] = pins_seven_eight_config[LO_OUT_BIT];
        cfg_dir[SLOT_P8] = pins_seven_eight_config[HI_DIR_BIT];
        cfg_en[SLOT_P8]  = pins_seven_eight_config[HI_EN_BIT];
        cfg_out[SLOT_P8] = pins_seven_eight_config[HI_OUT_BIT];
    end

    // ************************************************************
    // Pads
    // ************************************************************
    // One controller per pad; all get the far value, only pin three slots can drive it
    genvar g;
    generate
        for (g = 0; g < PAD_COUNT; g = g + 1) begin : g_pad
            pin_pad_ctrl u_pad (
                .ref_clk_i    (ref_clk_i),
                .rst_i        (rst_i),
                .direction_i  (cfg_dir[g]),
                .enable_i     (cfg_en[g]),
                .remote_i     (cfg_remote[g]),
                .remote_val_i (remote_pin_three_i),
                .out_value_i  (cfg_out[g]),
                .func_val_i   (func_value_i[g]),
                .pad_i        (pad_i[g]),
                .pad_o        (pad_o[g]),
                .pad_oe_o     (pad_oe_o[g]),
                .level_o      (sync_level[g])
            );
        end
    endgenerate

    // Copy of the synchronised levels for the functional side
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pad_level_o <= 6'h00;
        end else begin
            pad_level_o <= sync_level;
        end
    end

endmodule : gpio_pin_config_bank

`default_nettype wire

// ---- hdl/pin_pad_ctrl.sv ----
// One pad's mode decode, output drive and input synchroniser
`timescale 1ns/10ps
`default_nettype none

module pin_pad_ctrl
    import gpio_cfg_pkg::*;
(
    input  wire logic ref_clk_i,     // Register clock
    input  wire logic rst_i,         // Async reset, active high
    input  wire logic direction_i,   // Direction bit
    input  wire logic enable_i,      // Enable bit
    input  wire logic remote_i,      // Remote control on
    input  wire logic remote_val_i,  // Value from far end
    input  wire logic out_value_i,   // Locally written value
    input  wire logic func_val_i,    // Functional signal
    input  wire logic pad_i,         // Pad level in
    output logic      pad_o,         // Pad level out
    output logic      pad_oe_o,      // Pad output enable
    output logic      level_o        // Synchronised pad level
);

    // ************************************************************
    // Drive decode
    // ************************************************************
    logic      next_pad;
    logic      next_oe;
    pad_mode_t mode;
    logic      meta;

    assign mode = pad_mode_t'({direction_i, enable_i});

    // Remote control overrides the local mode pair entirely
    always_comb begin
        next_pad = 1'b0;
        next_oe  = 1'b0;
        // R2: remote forces output
        if (remote_i) begin
            next_pad = remote_val_i;
            next_oe  = 1'b1;
        end else begin
            // R3: mode pair decode
            case (mode)
                MODE_FUNC: begin
                    next_pad = func_val_i;
                    next_oe  = 1'b1;
                end
                // R1: local value driven
                MODE_GPIO_OUT: begin
                    next_pad = out_value_i;
                    next_oe  = 1'b1;
                end
                MODE_TRISTATE: begin
                    next_oe = 1'b0;
                end
                MODE_GPIO_IN: begin
                    next_oe = 1'b0;
                end
                default: begin
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    // Registered drive keeps pad outputs glitch free
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pad_o    <= 1'b0;
            pad_oe_o <= 1'b0;
        end else begin
            pad_o    <= next_pad;
            pad_oe_o <= next_oe;
        end
    end

    // ************************************************************
    // Input synchroniser
    // ************************************************************
    // R9: two-flop level sync
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta    <= 1'b0;
            level_o <= 1'b0;
        end else begin
            meta    <= pad_i;
            level_o <= meta;
        end
    end

endmodule : pin_pad_ctrl

`default_nettype wire

// ---- tb/gpio_pin_config_bank_assertions.sv ----
// Port-level checks for the pin configuration bank
`timescale 1ns/10ps
`default_nettype none

module gpio_bank_checker
    import gpio_cfg_pkg::*;
(
    input wire logic        ref_clk_i,          // Clock
    input wire logic        rst_i,              // Reset
    input wire logic [9:0]  avs_address_i,      // Address
    input wire logic        avs_read_i,         // Read
    input wire logic        avs_write_i,        // Write
    input wire logic [3:0]  avs_byteenable_i,   // Enables
    input wire logic [31:0] avs_writedata_i,    // Write data
    input wire logic [31:0] avs_readdata_o,     // Read data
    input wire logic        avs_waitrequest_o,  // Stall
    input wire logic        remote_pin_three_i, // Far value
    input wire logic [5:0]  pad_i,              // Pads in
    input wire logic [5:0]  pad_o,              // Pads out
    input wire logic [5:0]  pad_oe_o,           // Pad enables
    input wire logic [5:0]  pad_level_o,        // Levels
    input wire logic        strap_latched_o     // Strap
);
    logic [2:0] up_cnt;  // Edges since reset, saturating
    logic       wr_any;  // Write accepted with low byte on
    logic       wr56;    // Accepted write to pins 5/6
    logic       wr3;     // Accepted write to pin three

    // Startup count keeps settling cycles out of the checks
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) up_cnt <= 3'h0;
        else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
    end
    assign wr_any = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign wr56 = wr_any && avs_address_i == ADDR_PINS_56;
    assign wr3 = wr_any && avs_address_i == ADDR_PIN_THREE;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_local_drive: assert property (wr56 && avs_writedata_i[5:4] == 2'b01 |->
        ##2 pad_oe_o[SLOT_P6] && pad_o[SLOT_P6] == $past(avs_writedata_i[7], 2))
        else $error("local value not driven");
    // Slot index 0 or 1 follows the latched strap
    a_remote_force: assert property (wr3 && avs_writedata_i[2] |->
        ##2 pad_oe_o[strap_latched_o] && pad_o[strap_latched_o] == $past(remote_pin_three_i))
        else $error("remote value not forced");
    a_tristate_off: assert property (wr56 && avs_writedata_i[1:0] == 2'b10 |->
        ##2 !pad_oe_o[SLOT_P5]) else $error("tristate pad still driven");
    a_strap_reset: assert property (up_cnt == 3'h6 |-> pad_oe_o[SLOT_P3] &&
        pad_oe_o[SLOT_DP3] == !strap_latched_o) else $error("pin three reset mode wrong");
    a_three_nibble: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i == ADDR_PIN_THREE |-> avs_readdata_o[7:4] == 4'h0)
        else $error("pin three upper nibble set");
    a_low_pin_drive: assert property (wr56 && avs_writedata_i[1:0] == 2'b01 |->
        ##2 pad_oe_o[SLOT_P5] && pad_o[SLOT_P5] == $past(avs_writedata_i[3], 2))
        else $error("low pin value misplaced");
    a_read_width: assert property (avs_read_i && !avs_waitrequest_o |->
        avs_readdata_o[31:8] == '0) else $error("read data above byte");
    a_answer_bound: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |-> ##[1:8] !avs_waitrequest_o) else $error("bus request not answered");
    a_level_sync: assert property (up_cnt == 3'h7 |->
        pad_level_o == $past(pad_i, 3)) else $error("pad level latency wrong");
endmodule : gpio_bank_checker

bind gpio_pin_config_bank gpio_bank_checker chk (.ref_clk_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .remote_pin_three_i, .pad_i, .pad_o, .pad_oe_o, .pad_level_o,
    .strap_latched_o);
`default_nettype wire

// ---- tb/gpio_pin_config_bank_bench.sv ----
// Self-checking bench for the pin configuration bank
`timescale 1ns/10ps
`default_nettype none

module gpio_pin_config_bank_bench;
    import gpio_cfg_pkg::*;
    logic        ref_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, rem_d;
    logic        second_port_strap_i, remote_pin_three_i, strap_latched_o;
    logic [9:0]  avs_address_i;
    logic [3:0]  avs_byteenable_i, pace;
    logic [31:0] avs_writedata_i, avs_readdata_o, got;
    logic [5:0]  func_value_i, pad_i, pad_o, pad_oe_o, pad_level_o;
    logic [9:0]  addrs [3];
    int          model [3];
    int          num_errors, comparisons, seed, strap;

    gpio_pin_config_bank uut (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
        .avs_waitrequest_o, .second_port_strap_i, .remote_pin_three_i, .func_value_i,
        .pad_i, .pad_o, .pad_oe_o, .pad_level_o, .strap_latched_o);
    remote_serializer_model far (.ref_clk_i, .rst_i, .pace_i(pace),
        .remote_val_o(remote_pin_three_i));

    // Clock, and the far value as the pad flops see it
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) rem_d <= remote_pin_three_i;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One Avalon access; waits on waitrequest, the watchdog catches a hang
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] e, output logic [31:0] q);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= e;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge ref_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        check(avs_waitrequest_o, 32'h0000_0000);
        // Answer stands for one cycle only
        @(posedge ref_clk_i);
        check(avs_waitrequest_o, 32'h0000_0001);
    endtask : bus

    // Expected drive of all six pads from the register model
    task automatic check_pads();
        int r, m, rm, o;
        for (int k = 0; k < 6; k++) begin
            r = (k < 2) ? ((k == strap) ? model[0] : 0) : model[k / 4 + 1] >> ((k % 2) * 4);
            m = r & 3;
            rm = k < 2 && r[2];
            o = rm || m < 2;
            check(pad_oe_o[k], o);
            if (o) check(pad_o[k], rm ? rem_d : (m == 0 ? func_value_i[k] : r[3]));
        end
    endtask : check_pads

    // Reset with a given strap, then reset values and unmapped space
    task automatic do_reset(input int s);
        strap = s;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        second_port_strap_i <= s[0];
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        model = '{s ? 3 : 0, 0, 0};
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, addrs[i], 32'h0000_0000, 4'hf, got);
            check(got, model[i]);
        end
        @(negedge ref_clk_i);
        check_pads();
        check(strap_latched_o, s);
        bus(1'b0, 10'h3fc, 32'h0000_0000, 4'hf, got);
        check(got, 32'h0000_0000);
    endtask : do_reset

    // Random writes with random byte enables, pad and far-end pace
    task automatic run_random(input int n);
        int k;
        logic [7:0] d;
        logic [3:0] e;
        for (int i = 0; i < n; i++) begin
            k = $unsigned($random(seed)) % 3;
            d = $random(seed);
            e = $random(seed);
            @(posedge ref_clk_i);
            pace <= $random(seed);
            func_value_i <= $random(seed);
            pad_i <= $random(seed);
            bus(1'b1, addrs[k], {24'h00_0000, d}, e, got);
            // low byte enable gates the store
            if (e[0]) model[k] = (k == 0) ? d & 8'h0f : d;
            repeat (4) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            check_pads();
            bus(1'b0, addrs[k], 32'h0000_0000, 4'hf, got);
            check(got, model[k]);
            bus(1'b0, ADDR_PAD_LEVELS, 32'h0000_0000, 4'hf, got);
            check(got, {26'h0, pad_i});
            check(pad_level_o, pad_i);
        end
    endtask : run_random

    task automatic stop_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        seed = 32'h7fa2;
        num_errors = 0;
        comparisons = 0;
        rst_i = 1'b1;
        avs_address_i = 10'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_byteenable_i = 4'h0;
        avs_writedata_i = 32'h0000_0000;
        second_port_strap_i = 1'b0;
        func_value_i = 6'h00;
        pad_i = 6'h00;
        pace = 4'h0;
        addrs = '{ADDR_PIN_THREE, ADDR_PINS_56, ADDR_PINS_78};
        do_reset(0);
        run_random(40);
        do_reset(1);
        run_random(25);
        stop_test();
    end
    // Whole run needs well under 3000 cycles
    initial begin
        #1000000;
        num_errors++;
        stop_test();
    end
endmodule : gpio_pin_config_bank_bench
`default_nettype wire

// ---- tb/remote_serializer_model.sv ----
// Far-end serializer model feeding the remote pin three value
`timescale 1ns/10ps
`default_nettype none

module remote_serializer_model (
    input  wire logic       ref_clk_i,    // Shared clock
    input  wire logic       rst_i,        // Async reset
    input  wire logic [3:0] pace_i,       // Extra edges per value
    output logic            remote_val_o  // Forwarded pin value
);
    logic [3:0] gap;   // Edges the value has stood
    logic [7:0] lfsr;  // Pattern source

    // Slow pace stands for a sluggish link, zero for a prompt one
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap  <= 4'h0;
            lfsr <= 8'h5a;
        end else if (gap >= pace_i) begin
            gap  <= 4'h0;
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end else begin
            gap <= gap + 4'h1;
        end
    end
    assign remote_val_o = lfsr[0];
endmodule : remote_serializer_model
`default_nettype wire
